// ==== inc/loop_sink_pkg.sv ====
// loop_sink_pkg: constants and types for the vc loopback sink
// assumes a 20 MHz system clock and one 53-byte cell header view per beat
package loop_sink_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          CLK_HZ        = 20_000_000;
    localparam int          WAIT_SECONDS  = 5;
    localparam longint      WAIT_CYCLES   = longint'(WAIT_SECONDS) * longint'(CLK_HZ);
    localparam int          TICK_HZ       = 1000;
    localparam int          TICK_DIV      = CLK_HZ / TICK_HZ;
    localparam int          WAIT_TICKS    = WAIT_SECONDS * TICK_HZ;

    // ----------------------------------------------------------------
    // field widths and codes
    // ----------------------------------------------------------------
    localparam int          LLID_W        = 128;
    localparam int          SRCID_W       = 128;
    localparam logic [LLID_W-1:0] LLID_ALL_ONES = {LLID_W{1'b1}};

    // ----------------------------------------------------------------
    // wishbone register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0c;
    localparam logic [7:0]  ADDR_CPID0    = 8'h10;
    localparam logic [7:0]  ADDR_RES_LLID0 = 8'h20;
    localparam logic [7:0]  ADDR_RES_SRC0 = 8'h30;
    localparam int          CTRL_DISCARD_BIT = 0;
    localparam int          IRQ_OK_BIT    = 0;
    localparam int          IRQ_FAIL_BIT  = 1;
    localparam int          IRQ_FWD_BIT   = 2;
    localparam int          IRQ_W         = 3;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic               is_loop;    // f5 loopback oam cell
        logic               segment;    // 1 segment, 0 end-to-end
        logic               from_own;   // inserted by the companion source
        logic               lb_ind;     // loopback indication bit
        logic [LLID_W-1:0]  llid;
        logic [SRCID_W-1:0] src_id;
    } cell_info_t;

    typedef struct packed {
        logic [LLID_W-1:0]  llid;
        logic [SRCID_W-1:0] src_id;
    } echo_report_t;

    typedef enum logic [1:0] {
        OUT_NONE,
        OUT_OK,
        OUT_FAIL
    } outcome_t;

endpackage

// ==== verilog/wait_timer.sv ====
// wait_timer: response-wait window counter for the loopback sink
// assumes tick_i is a one-cycle enable from a divider
`timescale 1ns/1ns
module wait_timer
    import loop_sink_pkg::*;
#(
    parameter int TICKS = WAIT_TICKS
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic tick_i,
    input  wire logic start_i,
    input  wire logic stop_i,
    // state
    output logic      running_o,
    output logic      expired_o
);

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        run_reg;
    logic        run_next;
    logic        exp_next;

    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        exp_next = 1'b0;
        if (start_i) begin
            cnt_next = 32'(TICKS);
            run_next = 1'b1;
        end else if (stop_i) begin
            run_next = 1'b0;
        end else if (run_reg && tick_i) begin
            if (cnt_reg <= 32'h0000_0001) begin
                run_next = 1'b0;
                exp_next = 1'b1;
                cnt_next = 32'h0000_0000;
            end else begin
                cnt_next = cnt_reg - 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg   <= 32'h0000_0000;
            run_reg   <= 1'b0;
            expired_o <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            run_reg   <= run_next;
            expired_o <= exp_next;
        end
    end

    assign running_o = run_reg;

endmodule

// ==== verilog/tick_divider.sv ====
// tick_divider: slow enable pulse for the wait timer
// assumes a single system clock
`timescale 1ns/1ns
module tick_divider
    import loop_sink_pkg::*;
#(
    parameter int DIV = TICK_DIV
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // enable
    output logic      tick_o
);

    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic        tick_next;

    always_comb begin
        tick_next = 1'b0;
        cnt_next  = cnt_reg + 32'h0000_0001;
        if (cnt_reg >= 32'(DIV - 1)) begin
            cnt_next  = 32'h0000_0000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 32'h0000_0000;
            tick_o  <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_o  <= tick_next;
        end
    end

endmodule

// ==== verilog/vc_loop_sink.sv ====
// vc_loop_sink: sink side of vc f5 loopback handling
// assumes cells arrive as decoded header views with valid strobes, and a
// classic wishbone master reaches the registers on the same clock
// assumes the companion source pulses timer start once per request and
// spaces requests of one type beyond the response window
//
// How it works
// - with discard on, own end-to-end loopback cells are dropped from the flow
// - with discard on, own segment loopback cells are dropped from the flow
// - with discard on, the timer-start pulse starts a five second response window
// - end-to-end reply in window: success, report its llid and source id
// - no reply by window end: failure indication
// - end-to-end request to own cpid or all ones is copied to the source
// - segment request to own cpid or all ones is copied to the source
// - segment reply in window: success, report its llid and source id
// - first reply after the window: failure indication; every late reply cell is dropped
`timescale 1ns/1ns
module vc_loop_sink
    import loop_sink_pkg::*;
#(
    parameter int WAIT_TICK_COUNT = WAIT_TICKS,
    parameter int TICK_DIVIDE     = TICK_DIV
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // incoming cell stream
    input  wire logic          cell_valid_i,
    input  wire cell_info_t    cell_i,
    // outgoing cell stream
    output logic               cell_valid_o,
    output cell_info_t         cell_o,
    // companion loop source
    input  wire logic          wait_timer_start_i,
    output logic               reply_forward_o,
    output cell_info_t         reply_cell_o,
    // element management
    output logic               echo_success_ind_o,
    output logic               echo_failure_ind_o,
    output echo_report_t       echo_result_report_o,
    // wishbone slave
    input  wire logic          wb_cyc_i,
    input  wire logic          wb_stb_i,
    input  wire logic          wb_we_i,
    input  wire logic [7:0]    wb_adr_i,
    input  wire logic [3:0]    wb_sel_i,
    input  wire logic [31:0]   wb_dat_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    // interrupt
    output logic               irq_o
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic                discard_reg;
    logic                discard_next;
    logic [LLID_W-1:0]   cpid_reg;
    logic [LLID_W-1:0]   cpid_next;
    logic [IRQ_W-1:0]    istat_reg;
    logic [IRQ_W-1:0]    istat_next;
    logic [IRQ_W-1:0]    imask_reg;
    logic [IRQ_W-1:0]    imask_next;
    logic [31:0]         rdat_next;
    logic                ack_next;
    // a write lands on the edge that sees ack high, a read is
    // answered on the edge that raises ack
    logic                wr_fire;
    logic                rd_fire;
    logic                tick;
    logic                running;
    logic                expired;
    logic                tstart;
    logic                tstop;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] word_of(input logic [127:0] v, input logic [1:0] i);
        word_of = v[32*i +: 32];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        merge = r;
    endfunction

    // ----------------------------------------------------------------
    // response window timing
    // ----------------------------------------------------------------
    // one enable per millisecond keeps the window counter narrow
    tick_divider #(.DIV(TICK_DIVIDE)) u_div (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tick)
    );

    // window start
    // with discard off the start pulse is ignored here
    assign tstart = wait_timer_start_i && discard_reg;

    wait_timer #(.TICKS(WAIT_TICK_COUNT)) u_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (tick),
        .start_i   (tstart),
        .stop_i    (tstop),
        .running_o (running),
        .expired_o (expired)
    );

    // ----------------------------------------------------------------
    // cell handling
    // ----------------------------------------------------------------
    logic         fwd_next;
    logic         pass_next;
    logic         ok_next;
    logic         fail_next;
    echo_report_t rep_next;
    logic         addressed;
    logic         active_loop;
    // low after a start or an expiry: the first late reply then still
    // earns one failure, later ones are only dropped
    logic         reply_seen_reg;
    logic         reply_seen_next;

    always_comb begin
        fwd_next    = 1'b0;
        pass_next   = cell_valid_i;
        ok_next     = 1'b0;
        fail_next   = 1'b0;
        rep_next    = echo_result_report_o;
        tstop       = 1'b0;
        reply_seen_next = reply_seen_reg;
        // all ones addresses every loop point on the connection
        addressed   = (cell_i.llid == cpid_reg) || (cell_i.llid == LLID_ALL_ONES);
        // discard off: loop cells are ordinary traffic
        active_loop = cell_valid_i && cell_i.is_loop && discard_reg;
        if (tstart) begin
            reply_seen_next = 1'b0;
        end
        if (active_loop) begin
            if (cell_i.lb_ind) begin
                fwd_next = addressed;
                pass_next = !cell_i.from_own;
            end else begin
                pass_next = 1'b0;
                if (running) begin
                    ok_next  = 1'b1;
                    rep_next = '{llid: cell_i.llid, src_id: cell_i.src_id};
                    tstop    = 1'b1;
                    reply_seen_next = 1'b1;
                end else if (!reply_seen_reg) begin
                    // late reply fails and is dropped
                    fail_next = 1'b1;
                    reply_seen_next = 1'b1;
                end
            end
        end
        if (expired && !ok_next) begin
            fail_next = 1'b1;
            reply_seen_next = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // stream and outcome registers
    // ----------------------------------------------------------------
    // every cell is registered once; the strobes decide what leaves
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cell_valid_o         <= 1'b0;
            cell_o               <= '0;
            reply_forward_o      <= 1'b0;
            reply_cell_o         <= '0;
            echo_success_ind_o   <= 1'b0;
            echo_failure_ind_o   <= 1'b0;
            echo_result_report_o <= '0;
            reply_seen_reg       <= 1'b1;
        end else begin
            cell_valid_o         <= pass_next;
            cell_o               <= cell_i;
            reply_forward_o      <= fwd_next;
            reply_cell_o         <= cell_i;
            echo_success_ind_o   <= ok_next;
            echo_failure_ind_o   <= fail_next;
            echo_result_report_o <= rep_next;
            reply_seen_reg       <= reply_seen_next;
        end
    end

    // ----------------------------------------------------------------
    // wishbone registers
    // ----------------------------------------------------------------
    always_comb begin
        discard_next = discard_reg;
        cpid_next    = cpid_reg;
        imask_next   = imask_reg;
        istat_next   = istat_reg;
        rdat_next    = 32'h0000_0000;
        ack_next     = wb_cyc_i && wb_stb_i && !wb_ack_o;
        wr_fire      = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
        rd_fire      = ack_next && !wb_we_i;
        if (wr_fire) begin
            unique case (wb_adr_i)
                ADDR_CTRL: begin
                    if (wb_sel_i[0]) begin
                        discard_next = wb_dat_i[CTRL_DISCARD_BIT];
                    end
                end
                ADDR_IRQ_STAT: begin
                    // write one to clear
                    istat_next = istat_reg & ~wb_dat_i[IRQ_W-1:0];
                end
                ADDR_IRQ_MASK: begin
                    imask_next = wb_dat_i[IRQ_W-1:0];
                end
                // cpid words take byte lanes, low word first
                default: begin
                    for (int w = 0; w < 4; w++) begin
                        if (wb_adr_i == ADDR_CPID0 + 8'(4*w)) begin
                            cpid_next[32*w +: 32] = merge(cpid_reg[32*w +: 32],
                                                          wb_dat_i, wb_sel_i);
                        end
                    end
                end
            endcase
        end
        if (rd_fire) begin
            unique case (wb_adr_i)
                ADDR_CTRL:     rdat_next = {31'h0, discard_reg};
                ADDR_STATUS:   rdat_next = {31'h0, running};
                ADDR_IRQ_STAT: rdat_next = {29'h0, istat_reg};
                ADDR_IRQ_MASK: rdat_next = {29'h0, imask_reg};
                // unmapped addresses read as zero
                default: begin
                    for (int w = 0; w < 4; w++) begin
                        if (wb_adr_i == ADDR_CPID0 + 8'(4*w)) begin
                            rdat_next = word_of(cpid_reg, 2'(w));
                        end
                        if (wb_adr_i == ADDR_RES_LLID0 + 8'(4*w)) begin
                            rdat_next = word_of(echo_result_report_o.llid, 2'(w));
                        end
                        if (wb_adr_i == ADDR_RES_SRC0 + 8'(4*w)) begin
                            rdat_next = word_of(echo_result_report_o.src_id, 2'(w));
                        end
                    end
                end
            endcase
        end
        // events set after the clear, so set wins
        // a pulse in the clearing cycle is kept, never lost
        istat_next[IRQ_OK_BIT]   = istat_next[IRQ_OK_BIT]   | echo_success_ind_o;
        istat_next[IRQ_FAIL_BIT] = istat_next[IRQ_FAIL_BIT] | echo_failure_ind_o;
        istat_next[IRQ_FWD_BIT]  = istat_next[IRQ_FWD_BIT]  | reply_forward_o;
    end

    // ----------------------------------------------------------------
    // register update
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            discard_reg <= 1'b0;
            cpid_reg    <= '0;
            istat_reg   <= '0;
            imask_reg   <= '0;
            wb_dat_o    <= 32'h0000_0000;
            wb_ack_o    <= 1'b0;
            irq_o       <= 1'b0;
        end else begin
            discard_reg <= discard_next;
            cpid_reg    <= cpid_next;
            istat_reg   <= istat_next;
            imask_reg   <= imask_next;
            wb_dat_o    <= rdat_next;
            wb_ack_o    <= ack_next;
            // irq follows the next status so it drops with the clear
            irq_o       <= |(istat_next & imask_next);
        end
    end

endmodule

// ==== verif/vc_loop_sink_asserts.sv ====
// port checker for the vc loopback sink
// assumes short window parameters of a few cycles each
`timescale 1ns/1ns
module vc_loop_sink_checker
    import loop_sink_pkg::*;
#(
    parameter int WAIT_TICK_COUNT = WAIT_TICKS,
    parameter int TICK_DIVIDE     = TICK_DIV
) (
    // clock and reset
    input wire logic         clk_i,
    input wire logic         rst_i,
    // cells and companion
    input wire logic         cell_valid_i,
    input wire cell_info_t   cell_i,
    input wire logic         cell_valid_o,
    input wire cell_info_t   cell_o,
    input wire logic         wait_timer_start_i,
    input wire logic         reply_forward_o,
    input wire cell_info_t   reply_cell_o,
    input wire logic         echo_success_ind_o,
    input wire logic         echo_failure_ind_o,
    input wire echo_report_t echo_result_report_o,
    // wishbone
    input wire logic         wb_cyc_i,
    input wire logic         wb_stb_i,
    input wire logic         wb_we_i,
    input wire logic [7:0]   wb_adr_i,
    input wire logic [3:0]   wb_sel_i,
    input wire logic [31:0]  wb_dat_i,
    input wire logic         wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------------------------------
    // discard setting seen on the bus
    // ----------------------------------------------------------------
    logic disc_reg;
    logic disc_next;
    always_comb begin
        disc_next = disc_reg;
        if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
            && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
            disc_next = wb_dat_i[CTRL_DISCARD_BIT];
        end
    end
    always_ff @(posedge clk_i) begin
        disc_reg <= rst_i ? 1'b0 : disc_next;
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    fwd_copy_a:
        assert property (disc_reg && cell_valid_i && cell_i.is_loop && cell_i.lb_ind
            && !cell_i.from_own && cell_i.llid == LLID_ALL_ONES
            |=> reply_forward_o && reply_cell_o == $past(cell_i)) else $error("copy missing");
    fwd_cause_a:
        assert property (reply_forward_o |-> $past(disc_reg) && $past(cell_valid_i)
            && $past(cell_i.lb_ind)) else $error("copy without request");
    drop_own_a:
        assert property (disc_reg && cell_valid_i && cell_i.is_loop && cell_i.from_own
            && cell_i.lb_ind |=> !cell_valid_o) else $error("own cell passed");
    drop_reply_a:
        assert property (disc_reg && cell_valid_i && cell_i.is_loop && !cell_i.lb_ind
            |=> !cell_valid_o) else $error("reply cell passed");
    pass_off_a:
        assert property (!disc_reg && cell_valid_i |=> cell_valid_o
            && cell_o == $past(cell_i)) else $error("cell not passed");
    report_a:
        assert property (echo_success_ind_o |-> $past(cell_valid_i) && $past(cell_i.is_loop)
            && !$past(cell_i.lb_ind) && echo_result_report_o
            == {$past(cell_i.llid), $past(cell_i.src_id)}) else $error("bad report");
    window_end_a:
        assert property (disc_reg && wait_timer_start_i |-> ##[1:40]
            (echo_success_ind_o || echo_failure_ind_o)) else $error("no outcome");
    no_early_fail_a:
        assert property (disc_reg && wait_timer_start_i |=> !echo_failure_ind_o [*5])
            else $error("early failure");
    one_outcome_a:
        assert property (echo_success_ind_o |=> !echo_failure_ind_o [*8])
            else $error("second outcome");
endmodule

bind vc_loop_sink vc_loop_sink_checker #(
    .WAIT_TICK_COUNT(WAIT_TICK_COUNT),
    .TICK_DIVIDE(TICK_DIVIDE)
) chk_u (.clk_i, .rst_i, .cell_valid_i, .cell_i, .cell_valid_o, .cell_o,
    .wait_timer_start_i, .reply_forward_o, .reply_cell_o, .echo_success_ind_o,
    .echo_failure_ind_o, .echo_result_report_o, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o);

// ==== verif/companion_loop_source.sv ====
// companion source model: timer start and reply builder
// assumes the clock of the sink
`timescale 1ns/1ns
module companion_loop_source
    import loop_sink_pkg::*;
(
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // requests and copies
    input  wire logic              send_i,
    input  wire logic              fwd_i,
    input  wire cell_info_t        fwd_cell_i,
    input  wire logic [LLID_W-1:0] cpid_i,
    // towards sink and line
    output logic                   timer_start_o,
    output logic                   ret_valid_o,
    output cell_info_t             ret_cell_o
);
    cell_info_t ret_next;
    always_comb begin
        ret_next = fwd_cell_i;
        ret_next.lb_ind = 1'b0;
        ret_next.llid = cpid_i;
    end
    always_ff @(posedge clk_i) begin
        timer_start_o <= !rst_i && send_i;
        ret_valid_o <= !rst_i && fwd_i;
        ret_cell_o <= ret_next;
    end
endmodule

// ==== verif/atm_vc_loopback_sink_bench.sv ====
// bench for the vc loopback sink with queued expectations
// assumes short window parameters and the companion model
`timescale 1ns/1ns
module atm_vc_loopback_sink_bench;
    import loop_sink_pkg::*;
    typedef logic [259:0] wide_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cell_valid_i = 1'b0;
    cell_info_t cell_i = '0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0;
    logic send_req = 1'b0;
    logic wait_timer_start_i;
    logic cell_valid_o;
    logic reply_forward_o;
    logic echo_success_ind_o;
    logic echo_failure_ind_o;
    logic wb_ack_o;
    logic irq_o;
    logic [31:0] wb_dat_o;
    cell_info_t cell_o;
    cell_info_t reply_cell_o;
    cell_info_t ret_cell;
    cell_info_t last_ret;
    echo_report_t echo_result_report_o;
    logic ret_valid;
    logic disc = 1'b0;
    logic [127:0] cpid;
    cell_info_t q_cell[$];
    cell_info_t q_fwd[$];
    echo_report_t q_rep[$];
    logic [31:0] q_rd[$];
    int n_fail = 0;
    int n_compared = 0;
    int n_ok = 0;
    int n_bad = 0;

    always #25 clk_i = ~clk_i;

    vc_loop_sink #(.WAIT_TICK_COUNT(4), .TICK_DIVIDE(2)) dut_u (.clk_i, .rst_i,
        .cell_valid_i, .cell_i, .cell_valid_o, .cell_o, .wait_timer_start_i,
        .reply_forward_o, .reply_cell_o, .echo_success_ind_o, .echo_failure_ind_o,
        .echo_result_report_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o);
    companion_loop_source src_u (.clk_i(clk_i), .rst_i(rst_i), .send_i(send_req),
        .fwd_i(reply_forward_o), .fwd_cell_i(reply_cell_o), .cpid_i(cpid),
        .timer_start_o(wait_timer_start_i), .ret_valid_o(ret_valid),
        .ret_cell_o(ret_cell));

    // ----------------------------------------------------------------
    // compare, close and drive
    // ----------------------------------------------------------------
    task automatic check(input wide_t seen, input wide_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wait_cnt(ref int c, input int v);
        int i;
        for (i = 0; i < 60 && c < v; i++) @(posedge clk_i);
        if (c < v) begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e);
        int i;
        if (!w) q_rd.push_back(e);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 50) begin
            n_fail++;
            conclude();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    function automatic cell_info_t rnd();
        logic [287:0] r;
        repeat (9) r = {r[255:0], $urandom()};
        return r[259:0];
    endfunction
    task automatic send(input cell_info_t c);
        if (!disc || !c.is_loop || (c.lb_ind && !c.from_own)) q_cell.push_back(c);
        if (disc && c.is_loop && c.lb_ind && !c.from_own
            && (c.llid == cpid || c.llid == LLID_ALL_ONES)) q_fwd.push_back(c);
        cell_valid_i <= 1'b1;
        cell_i <= c;
        @(posedge clk_i);
    endtask
    task automatic idle(input int n);
        cell_valid_i <= 1'b0;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic start();
        send_req <= 1'b1;
        @(posedge clk_i);
        send_req <= 1'b0;
        @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        if (cell_valid_o) check(cell_o, q_cell.size() ? q_cell.pop_front() : 'x);
        if (reply_forward_o) check(reply_cell_o, q_fwd.size() ? q_fwd.pop_front() : 'x);
        if (echo_success_ind_o)
            check(echo_result_report_o, q_rep.size() ? q_rep.pop_front() : 'x);
        if (wb_ack_o && !wb_we_i) check(wb_dat_o, q_rd.size() ? q_rd.pop_front() : 'x);
        n_ok += int'(echo_success_ind_o === 1'b1);
        n_bad += int'(echo_failure_ind_o === 1'b1);
        if (ret_valid) last_ret = ret_cell;
    end

    initial begin
        int k;
        cell_info_t c;
        void'($urandom(9387));
        cpid = {$urandom(), $urandom(), $urandom(), $urandom()};
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        disc = 1'b1;
        wb(1'b1, ADDR_CTRL, 32'h1, 32'h0);
        for (k = 0; k < 4; k++) wb(1'b1, ADDR_CPID0 + 8'(4 * k), cpid[32 * k +: 32], 32'h0);
        wb(1'b1, ADDR_IRQ_MASK, 32'h2, 32'h0);
        wb(1'b0, 8'h40, 32'h0, 32'h0);
        wb(1'b0, ADDR_CTRL, 32'h0, 32'h1);
        for (k = 0; k < 8; k++) begin
            c = rnd();
            c.is_loop = 1'b1;
            c.lb_ind = 1'b1;
            c.segment = k[2];
            c.from_own = k[1:0] == 2'h3;
            if (k[1:0] < 2) c.llid = k[0] ? LLID_ALL_ONES : cpid;
            send(c);
        end
        idle(12);
        for (k = 0; k < 2; k++) begin
            start();
            c = k ? rnd() : last_ret;
            c.is_loop = 1'b1;
            c.lb_ind = 1'b0;
            c.segment = !k[0];
            c.from_own = 1'b0;
            q_rep.push_back({c.llid, c.src_id});
            send(c);
            idle(1);
            wait_cnt(n_ok, k + 1);
            idle(12);
        end
        wb(1'b1, ADDR_IRQ_STAT, 32'h7, 32'h0);
        start();
        wait_cnt(n_bad, 1);
        @(posedge clk_i);
        check(irq_o, 1'b1);
        wb(1'b0, ADDR_IRQ_STAT, 32'h0, 32'h2);
        wb(1'b1, ADDR_IRQ_STAT, 32'h2, 32'h0);
        check(irq_o, 1'b0);
        send(c);
        idle(1);
        wait_cnt(n_bad, 2);
        idle(12);
        disc = 1'b0;
        wb(1'b1, ADDR_CTRL, 32'h0, 32'h0);
        for (k = 0; k < 4; k++) begin
            c = rnd();
            c.is_loop = 1'b1;
            c.lb_ind = k[0];
            send(c);
        end
        idle(1);
        start();
        idle(20);
        check(n_ok + n_bad, 4);
        check(q_cell.size() + q_fwd.size() + q_rep.size() + q_rd.size(), 0);
        conclude();
    end
endmodule
